// ---- rtl/dtc_top.v ----
// Dual timer/counter with external interrupt flags, reached through the special function port.
//
// Operation
// RQ1: Software uses reload mode on timer a only when timer b uses it too.
// RQ2: With gate and run set, count each falling edge of the gating input.
// RQ3: Counter/timer select bit one counts input edges, zero counts machine cycles.
// RQ4: Two 2-bit mode fields, one per timer, select among four modes.
// RQ5: Timer b overflow sets its flag; software or interrupt service clears it. While timer a is split, the flag takes timer a's high-byte overflow instead.
// RQ6: Timer a overflow sets its flag; software or interrupt service clears it.
// RQ7: Timer b counts only while its run bit is set.
// RQ8: Timer a counts only while its run bit is set. In split mode its high byte counts under timer b's run bit instead.
// RQ9: Falling edge on interrupt input b sets its flag; service clears it.
// RQ10: Falling edge on interrupt input a sets its flag; service clears it.
// RQ11: Type bit selects falling edge or low level for each interrupt input.
// RQ12: No software watchdog is built in; the hardware watchdog supervises.
// RQ13: Timer operation advances once per machine cycle of twelve clocks.
// RQ14: Modes are 13-bit, 16-bit, 8-bit auto-reload, and split/stop.
// RQ15: Type zero means low level, type one means falling edge.
// RQ16: Edge recognition takes two machine cycles; inputs hold each level one cycle.
// RQ17: 13-bit and 16-bit counts wrap to zero and keep running.
`timescale 1ns/10ps
`include "dtc_defines.vh"
module dtc_top #(
   parameter MC_CLKS = `DTC_MC_CLKS
) (
   // Clock and reset.
   input  wire       clock_i,
   input  wire       sys_rst_i,
   // Special function register port.
   input  wire [7:0] sfr_addr_i,
   input  wire [7:0] sfr_wdata_i,
   input  wire       sfr_wr_i,
   input  wire       sfr_rd_i,
   output reg  [7:0] sfr_rdata_o,
   // Gating inputs routed from the shared I/O pins.
   input  wire       cnt_a_input_i,
   input  wire       cnt_b_input_i,
   // External interrupt inputs.
   input  wire       ext_irq_a_input_i,
   input  wire       ext_irq_b_input_i,
   // Interrupt service acknowledges.
   input  wire       tmr_a_ack_i,
   input  wire       tmr_b_ack_i,
   input  wire       ext_irq_a_ack_i,
   input  wire       ext_irq_b_ack_i,
   // Interrupt request flags.
   output wire       timer_a_overflow_flag_o,
   output wire       timer_b_overflow_flag_o,
   output wire       ext_irq_a_edge_flag_o,
   output wire       ext_irq_b_edge_flag_o
);

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   localparam [7:0] RST_CTRL = `DTC_RST_CTRL;
   reg  [3:0] presc;
   reg        mc_tick;
   reg  [7:0] timer_mode_select;
   reg        timer_a_run;
   reg        timer_b_run;
   reg        ext_irq_a_type;
   reg        ext_irq_b_type;
   reg        timer_a_overflow_flag;
   reg        timer_b_overflow_flag;
   reg        ext_irq_a_edge_flag;
   reg        ext_irq_b_edge_flag;
   reg  [7:0] next_rdata;
   wire [3:0] fall;
   wire [3:0] low;
   wire [1:0] mode_a;
   wire [1:0] mode_b;
   wire       gate_a;
   wire       gate_b;
   wire       ct_a;
   wire       ct_b;
   wire       src_a;
   wire       src_b;
   wire       tick_a_lo;
   wire       tick_a_hi;
   wire       tick_b_lo;
   wire [7:0] a_low;
   wire [7:0] a_high;
   wire [7:0] b_low;
   wire [7:0] b_high;
   wire       a_ovf_lo;
   wire       a_ovf_hi;
   wire       b_ovf_lo;
   wire       a_ovf_evt;
   wire       b_ovf_evt;
   wire       wr_ctrl;
   wire       wr_mode;
   wire [7:0] ctrl_value;

   // ****************************************************************
   // Helper functions.
   // ****************************************************************
   // Write strobe for one register offset.
   function wr_hit;
      input       wr;
      input [7:0] addr;
      input [7:0] offs;
      begin
         wr_hit = wr & (addr == offs);
      end
   endfunction

   // Sticky flag update: a hardware set wins over any clear in the same cycle.
   function flag_next;
      input cur;
      input set;
      input sw_wr;
      input sw_val;
      input ack;
      begin
         if (set) begin
            flag_next = 1'b1;
         end else if (sw_wr) begin
            flag_next = sw_val;
         end else begin
            flag_next = cur & ~ack;
         end
      end
   endfunction

   // ****************************************************************
   // Machine cycle prescaler.
   // ****************************************************************
   // One pulse every MC_CLKS clocks paces timer counting and input sampling.
   // Supervision stays with the separate hardware watchdog; nothing here restarts the core. RQ12
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         presc   <= 4'h0;
         mc_tick <= 1'b0;
      end else if (presc == MC_CLKS[3:0] - 4'h1) begin
         presc   <= 4'h0;
         mc_tick <= 1'b1; // RQ13
      end else begin
         presc   <= presc + 4'h1;
         mc_tick <= 1'b0;
      end
   end

   // ****************************************************************
   // Input sampling.
   // ****************************************************************
   // Bits: 0 gating a, 1 gating b, 2 interrupt a, 3 interrupt b.
   // Sampling at machine cycle rate caps the count rate well below the clock. RQ16
   dtc_edge_sampler #(
      .W        (4)
   ) u_sampler (
      .clock_i  (clock_i),
      .sys_rst_i(sys_rst_i),
      .sample_i (mc_tick),
      .level_i  ({ext_irq_b_input_i, ext_irq_a_input_i, cnt_b_input_i, cnt_a_input_i}),
      .fall_o   (fall),
      .low_o    (low)
   );

   // ****************************************************************
   // Mode fields and count sources.
   // ****************************************************************
   // Upper nibble steers timer b, lower nibble timer a.
   assign mode_a = timer_mode_select[`DTC_NIB_A_LSB + 1:`DTC_NIB_A_LSB]; // RQ4
   assign mode_b = timer_mode_select[`DTC_NIB_B_LSB + 1:`DTC_NIB_B_LSB]; // RQ4
   assign gate_a = timer_mode_select[`DTC_NIB_A_LSB + `DTC_NIB_GATE];
   assign gate_b = timer_mode_select[`DTC_NIB_B_LSB + `DTC_NIB_GATE];
   assign ct_a   = timer_mode_select[`DTC_NIB_A_LSB + `DTC_NIB_CT];
   assign ct_b   = timer_mode_select[`DTC_NIB_B_LSB + `DTC_NIB_CT];

   // Counter operation or gate control counts input edges; otherwise machine cycles.
   assign src_a = (ct_a | gate_a) ? fall[0] : mc_tick; // RQ2 RQ3
   assign src_b = (ct_b | gate_b) ? fall[1] : mc_tick; // RQ2 RQ3

   // Run bits stop the count; timer b also stops in its own split mode.
   assign tick_a_lo = timer_a_run & src_a; // RQ8
   assign tick_b_lo = timer_b_run & src_b & (mode_b != `DTC_MODE_SPLIT); // RQ7 RQ14
   // In split mode the high byte of timer a runs on machine cycles under timer b's run bit.
   assign tick_a_hi = timer_b_run & mc_tick & (mode_a == `DTC_MODE_SPLIT); // RQ14

   // ****************************************************************
   // Timer units.
   // ****************************************************************
   dtc_timer_unit u_timer_a (
      .clock_i  (clock_i),
      .sys_rst_i(sys_rst_i),
      .mode_i   (mode_a),
      .tick_lo_i(tick_a_lo),
      .tick_hi_i(tick_a_hi),
      .wr_lo_i  (wr_hit(sfr_wr_i, sfr_addr_i, `DTC_ADDR_A_LOW)),
      .wr_hi_i  (wr_hit(sfr_wr_i, sfr_addr_i, `DTC_ADDR_A_HIGH)),
      .wdata_i  (sfr_wdata_i),
      .low_o    (a_low),
      .high_o   (a_high),
      .ovf_lo_o (a_ovf_lo),
      .ovf_hi_o (a_ovf_hi)
   );

   dtc_timer_unit u_timer_b (
      .clock_i  (clock_i),
      .sys_rst_i(sys_rst_i),
      .mode_i   (mode_b),
      .tick_lo_i(tick_b_lo),
      .tick_hi_i(1'b0),
      .wr_lo_i  (wr_hit(sfr_wr_i, sfr_addr_i, `DTC_ADDR_B_LOW)),
      .wr_hi_i  (wr_hit(sfr_wr_i, sfr_addr_i, `DTC_ADDR_B_HIGH)),
      .wdata_i  (sfr_wdata_i),
      .low_o    (b_low),
      .high_o   (b_high),
      .ovf_lo_o (b_ovf_lo),
      .ovf_hi_o ()
   );

   // While timer a is split, its high byte owns timer b's overflow flag.
   assign a_ovf_evt = a_ovf_lo;
   assign b_ovf_evt = (mode_a == `DTC_MODE_SPLIT) ? a_ovf_hi : b_ovf_lo;

   // ****************************************************************
   // Control and mode registers.
   // ****************************************************************
   assign wr_ctrl = wr_hit(sfr_wr_i, sfr_addr_i, `DTC_ADDR_CTRL);
   assign wr_mode = wr_hit(sfr_wr_i, sfr_addr_i, `DTC_ADDR_MODE);

   // Mode register and the software-owned control bits.
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         timer_mode_select <= `DTC_RST_MODE;
         timer_a_run       <= RST_CTRL[`DTC_CTL_A_RUN];
         timer_b_run       <= RST_CTRL[`DTC_CTL_B_RUN];
         ext_irq_a_type    <= RST_CTRL[`DTC_CTL_XA_TYPE];
         ext_irq_b_type    <= RST_CTRL[`DTC_CTL_XB_TYPE];
      end else begin
         if (wr_mode) begin
            timer_mode_select <= sfr_wdata_i; // RQ4
         end
         if (wr_ctrl) begin
            timer_a_run    <= sfr_wdata_i[`DTC_CTL_A_RUN]; // RQ8
            timer_b_run    <= sfr_wdata_i[`DTC_CTL_B_RUN]; // RQ7
            ext_irq_a_type <= sfr_wdata_i[`DTC_CTL_XA_TYPE]; // RQ11
            ext_irq_b_type <= sfr_wdata_i[`DTC_CTL_XB_TYPE]; // RQ11
         end
      end
   end

   // ****************************************************************
   // Event flags.
   // ****************************************************************
   // Overflow flags: hardware set, software write, or service acknowledge.
   // An external flag in level mode mirrors the sampled low level instead of latching,
   // so the request drops by itself once the source releases the line.
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         timer_a_overflow_flag <= 1'b0;
         timer_b_overflow_flag <= 1'b0;
         ext_irq_a_edge_flag   <= 1'b0;
         ext_irq_b_edge_flag   <= 1'b0;
      end else begin
         timer_a_overflow_flag <= flag_next(timer_a_overflow_flag, a_ovf_evt, wr_ctrl,
            sfr_wdata_i[`DTC_CTL_A_OVF], tmr_a_ack_i); // RQ6
         timer_b_overflow_flag <= flag_next(timer_b_overflow_flag, b_ovf_evt, wr_ctrl,
            sfr_wdata_i[`DTC_CTL_B_OVF], tmr_b_ack_i); // RQ5
         if (ext_irq_a_type) begin
            ext_irq_a_edge_flag <= flag_next(ext_irq_a_edge_flag, fall[2], wr_ctrl,
               sfr_wdata_i[`DTC_CTL_XA_FLAG], ext_irq_a_ack_i); // RQ10 RQ15
         end else begin
            ext_irq_a_edge_flag <= low[2]; // RQ11 RQ15
         end
         if (ext_irq_b_type) begin
            ext_irq_b_edge_flag <= flag_next(ext_irq_b_edge_flag, fall[3], wr_ctrl,
               sfr_wdata_i[`DTC_CTL_XB_FLAG], ext_irq_b_ack_i); // RQ9 RQ15
         end else begin
            ext_irq_b_edge_flag <= low[3]; // RQ11 RQ15
         end
      end
   end

   assign timer_a_overflow_flag_o = timer_a_overflow_flag;
   assign timer_b_overflow_flag_o = timer_b_overflow_flag;
   assign ext_irq_a_edge_flag_o   = ext_irq_a_edge_flag;
   assign ext_irq_b_edge_flag_o   = ext_irq_b_edge_flag;

   // ****************************************************************
   // Register read back.
   // ****************************************************************
   assign ctrl_value = {timer_b_overflow_flag, timer_b_run,
                        timer_a_overflow_flag, timer_a_run,
                        ext_irq_b_edge_flag, ext_irq_b_type,
                        ext_irq_a_edge_flag, ext_irq_a_type};

   // Unmapped offsets read as zero.
   always @* begin
      case (sfr_addr_i)
         `DTC_ADDR_CTRL:   next_rdata = ctrl_value;
         `DTC_ADDR_MODE:   next_rdata = timer_mode_select;
         `DTC_ADDR_A_LOW:  next_rdata = a_low;
         `DTC_ADDR_B_LOW:  next_rdata = b_low;
         `DTC_ADDR_A_HIGH: next_rdata = a_high;
         `DTC_ADDR_B_HIGH: next_rdata = b_high;
         default:          next_rdata = 8'h00;
      endcase
   end

   // Read data is registered and returns one cycle after the strobe; zero otherwise.
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         sfr_rdata_o <= next_rdata;
      end else begin
         sfr_rdata_o <= 8'h00;
      end
   end

endmodule // dtc_top

// ---- shared/dtc_defines.vh ----
// Register offsets, field positions, reset values and timing counts of the dual timer/counter.
`ifndef DTC_DEFINES_VH
`define DTC_DEFINES_VH

// ****************************************************************
// Register offsets on the special function register port.
// ****************************************************************
`define DTC_ADDR_CTRL      8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_A_LOW     8'h8A
`define DTC_ADDR_B_LOW     8'h8B
`define DTC_ADDR_A_HIGH    8'h8C
`define DTC_ADDR_B_HIGH    8'h8D

// ****************************************************************
// Field positions in timer_control_flags.
// ****************************************************************
`define DTC_CTL_B_OVF      7
`define DTC_CTL_B_RUN      6
`define DTC_CTL_A_OVF      5
`define DTC_CTL_A_RUN      4
`define DTC_CTL_XB_FLAG    3
`define DTC_CTL_XB_TYPE    2
`define DTC_CTL_XA_FLAG    1
`define DTC_CTL_XA_TYPE    0

// ****************************************************************
// Field positions in timer_mode_select, per four-bit nibble.
// ****************************************************************
`define DTC_NIB_B_LSB      4
`define DTC_NIB_A_LSB      0
`define DTC_NIB_GATE       3
`define DTC_NIB_CT         2
`define DTC_NIB_MODE_MSB   1

// ****************************************************************
// Operating mode encodings.
// ****************************************************************
`define DTC_MODE_13BIT     2'h0
`define DTC_MODE_16BIT     2'h1
`define DTC_MODE_RELOAD    2'h2
`define DTC_MODE_SPLIT     2'h3

// ****************************************************************
// Reset values and timing.
// ****************************************************************
`define DTC_RST_CTRL       8'h00
`define DTC_RST_MODE       8'h00
`define DTC_RST_COUNT      8'h00
`define DTC_MC_CLKS        12

`endif

// ---- rtl/dtc_edge_sampler.v ----
// Per machine cycle sampler that reports falling edges and low levels of a group of inputs.
`timescale 1ns/10ps
module dtc_edge_sampler #(
   parameter W = 4
) (
   // Clock and reset.
   input  wire         clock_i,
   input  wire         sys_rst_i,
   // Sample strobe and inputs.
   input  wire         sample_i,
   input  wire [W-1:0] level_i,
   // Results.
   output reg  [W-1:0] fall_o,
   output wire [W-1:0] low_o
);

   reg [W-1:0] cur;

   // ****************************************************************
   // Sampling.
   // ****************************************************************
   // Inputs are taken once per machine cycle, so an edge is seen only after a high sample
   // and then a low sample; this is why each level must stand for a full machine cycle.
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         cur    <= {W{1'b1}};
         fall_o <= {W{1'b0}};
      end else if (sample_i) begin
         cur    <= level_i;
         fall_o <= cur & ~level_i;
      end else begin
         fall_o <= {W{1'b0}};
      end
   end

   // The low level follows the latest sample.
   assign low_o = ~cur;

endmodule // dtc_edge_sampler

// ---- rtl/dtc_timer_unit.v ----
// One timer/counter: low and high count bytes with the four operating modes.
`timescale 1ns/10ps
`include "dtc_defines.vh"
module dtc_timer_unit (
   // Clock and reset.
   input  wire       clock_i,
   input  wire       sys_rst_i,
   // Mode and count strobes.
   input  wire [1:0] mode_i,
   input  wire       tick_lo_i,
   input  wire       tick_hi_i,
   // Software writes to the count bytes.
   input  wire       wr_lo_i,
   input  wire       wr_hi_i,
   input  wire [7:0] wdata_i,
   // Count bytes and overflow pulses.
   output reg  [7:0] low_o,
   output reg  [7:0] high_o,
   output reg        ovf_lo_o,
   output reg        ovf_hi_o
);

   reg [7:0] next_low;
   reg [7:0] next_high;

   // ****************************************************************
   // Next count value.
   // ****************************************************************
   // A software write wins over a count in the same cycle, so a reload never loses bits.
   always @* begin
      next_low  = low_o;
      next_high = high_o;
      ovf_lo_o  = 1'b0;
      ovf_hi_o  = 1'b0;
      case (mode_i)
         `DTC_MODE_13BIT: begin
            if (tick_lo_i) begin
               if (low_o[4:0] == 5'h1F) begin
                  next_low  = 8'h00;
                  next_high = high_o + 8'h01;
                  ovf_lo_o  = (high_o == 8'hFF); // RQ17
               end else begin
                  next_low  = {3'h0, low_o[4:0] + 5'h01}; // RQ14
               end
            end
         end
         `DTC_MODE_16BIT: begin
            if (tick_lo_i) begin
               {next_high, next_low} = {high_o, low_o} + 16'h0001; // RQ17
               ovf_lo_o  = &{high_o, low_o};
            end
         end
         `DTC_MODE_RELOAD: begin
            if (tick_lo_i) begin
               if (low_o == 8'hFF) begin
                  next_low = high_o; // RQ14
                  ovf_lo_o = 1'b1;
               end else begin
                  next_low = low_o + 8'h01;
               end
            end
         end
         `DTC_MODE_SPLIT: begin
            if (tick_lo_i) begin
               next_low = low_o + 8'h01; // RQ14
               ovf_lo_o = &low_o;
            end
            if (tick_hi_i) begin
               next_high = high_o + 8'h01;
               ovf_hi_o  = &high_o;
            end
         end
         default: begin
            next_low = low_o;
         end
      endcase
      if (wr_lo_i) begin
         next_low = (mode_i == `DTC_MODE_13BIT) ? {3'h0, wdata_i[4:0]} : wdata_i;
      end
      if (wr_hi_i) begin
         next_high = wdata_i;
      end
   end

   // Count registers.
   always @(posedge clock_i) begin
      if (sys_rst_i) begin
         low_o  <= `DTC_RST_COUNT;
         high_o <= `DTC_RST_COUNT;
      end else begin
         low_o  <= next_low;
         high_o <= next_high;
      end
   end

endmodule // dtc_timer_unit

// ---- verification/dtc_top_chk.sv ----
// Port-level checks of the dual timer/counter.
`timescale 1ns/10ps
module dtc_top_chk #(
   parameter MC_CLKS = 12
) (
   // Clock and reset.
   input wire logic       clock_i,
   input wire logic       sys_rst_i,
   // Register port.
   input wire logic [7:0] sfr_addr_i,
   input wire logic [7:0] sfr_wdata_i,
   input wire logic       sfr_wr_i,
   input wire logic       sfr_rd_i,
   input wire logic [7:0] sfr_rdata_o,
   // Pins, acknowledges and flags.
   input wire logic       ext_irq_a_input_i,
   input wire logic       ext_irq_b_input_i,
   input wire logic       tmr_a_ack_i,
   input wire logic       tmr_b_ack_i,
   input wire logic       timer_a_overflow_flag_o,
   input wire logic       timer_b_overflow_flag_o,
   input wire logic       ext_irq_a_edge_flag_o,
   input wire logic       ext_irq_b_edge_flag_o
);
   logic        ctl_wr;
   int unsigned hi_a = 0;
   int unsigned hi_b = 0;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);

   // A control write may set a flag on purpose, so it restarts the quiet counts.
   assign ctl_wr = sfr_wr_i && sfr_addr_i == 8'h88;

   // Cycles each interrupt input has stayed high with no control write.
   always @(posedge clock_i) begin
      hi_a <= (sys_rst_i || ctl_wr || !ext_irq_a_input_i) ? 0 : hi_a + (hi_a < 999);
      hi_b <= (sys_rst_i || ctl_wr || !ext_irq_b_input_i) ? 0 : hi_b + (hi_b < 999);
   end

   sequence mode_wr_s;
      sfr_wr_i && sfr_addr_i == 8'h89;
   endsequence
   sequence mode_rd_s;
      sfr_rd_i && !sfr_wr_i && sfr_addr_i == 8'h89;
   endsequence

   rd_idle_a: assert property (!sfr_rd_i |=> sfr_rdata_o == 8'h00)
      else $error("read data not zero outside a read");
   unmapped_rd_a: assert property (sfr_rd_i && (sfr_addr_i < 8'h88 || sfr_addr_i > 8'h8D)
      |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
   mode_readback_a: assert property (mode_wr_s ##2 mode_rd_s |=>
      sfr_rdata_o == $past(sfr_wdata_i, 3)) else $error("mode register readback wrong");
   a_flag_hold_a: assert property (timer_a_overflow_flag_o && !tmr_a_ack_i && !ctl_wr
      |=> timer_a_overflow_flag_o) else $error("timer a flag dropped");
   b_flag_hold_a: assert property (timer_b_overflow_flag_o && !tmr_b_ack_i && !ctl_wr
      |=> timer_b_overflow_flag_o) else $error("timer b flag dropped");
   a_ack_clear_a: assert property (tmr_a_ack_i && !ctl_wr |=> !timer_a_overflow_flag_o)
      else $error("timer a flag survived service");
   b_ack_clear_a: assert property (tmr_b_ack_i && !ctl_wr |=> !timer_b_overflow_flag_o)
      else $error("timer b flag survived service");
   xa_quiet_a: assert property (hi_a > 3 * MC_CLKS |-> !$rose(ext_irq_a_edge_flag_o))
      else $error("interrupt a flag rose with input high");
   xb_quiet_a: assert property (hi_b > 3 * MC_CLKS |-> !$rose(ext_irq_b_edge_flag_o))
      else $error("interrupt b flag rose with input high");
endmodule // dtc_top_chk

// ---- verification/dtc_pin_model.sv ----
// Far-side model of the counting and external interrupt pins.
`timescale 1ns/10ps
module dtc_pin_model #(
   parameter HOLD = 24
) (
   // Clock and pulse requests.
   input  wire logic       clock_i,
   input  wire logic [3:0] pulse_i,
   // Pins: count a, count b, interrupt a, interrupt b.
   output logic      [3:0] pin_o
);
   int unsigned left [4] = '{0, 0, 0, 0};

   // A request drops its pin for HOLD clocks, then keeps it high as long before the next.
   always @(posedge clock_i) begin
      for (int k = 0; k < 4; k++) begin
         if (left[k] != 0)
            left[k] <= left[k] - 1;
         else if (pulse_i[k])
            left[k] <= 2 * HOLD;
      end
   end

   // Idle level is high; each level lasts at least two machine cycles.
   always_comb begin
      for (int k = 0; k < 4; k++)
         pin_o[k] = (left[k] <= HOLD);
   end
endmodule // dtc_pin_model

// ---- verification/dtc_top_tb.sv ----
// Self-checking bench for the dual timer/counter.
`timescale 1ns/10ps
`include "dtc_defines.vh"
module dtc_top_tb;
   logic       clock_i = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic [3:0] pulse = 4'h0;
   logic [3:0] ack = 4'h0;
   wire  [7:0] rdata;
   wire  [3:0] pin;
   wire  [3:0] flg;
   int         n_mismatch = 0;
   int         n_compared = 0;

   // Clock of 100 ns period.
   always #50 clock_i = ~clock_i;

   dtc_top #(.MC_CLKS(12)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
      .sfr_addr_i(addr), .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd),
      .sfr_rdata_o(rdata), .cnt_a_input_i(pin[0]), .cnt_b_input_i(pin[1]),
      .ext_irq_a_input_i(pin[2]), .ext_irq_b_input_i(pin[3]),
      .tmr_a_ack_i(ack[0]), .tmr_b_ack_i(ack[1]),
      .ext_irq_a_ack_i(ack[2]), .ext_irq_b_ack_i(ack[3]),
      .timer_a_overflow_flag_o(flg[0]), .timer_b_overflow_flag_o(flg[1]),
      .ext_irq_a_edge_flag_o(flg[2]), .ext_irq_b_edge_flag_o(flg[3]));
   dtc_pin_model #(.HOLD(24)) pins (.clock_i(clock_i), .pulse_i(pulse), .pin_o(pin));

   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   // Every strobe is held one edge, then a further edge passes before the next.
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      step(1);
      wr = 1'b0;
      step(1);
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      step(1);
      rd = 1'b0;
      check(rdata, exp);
      step(1);
   endtask
   task automatic hit(ref logic [3:0] s, input int k);
      s[k] = 1'b1;
      step(1);
      s[k] = 1'b0;
      step(1);
   endtask
   task automatic wait_hi(input int k, input int lim);
      while (flg[k] !== 1'b1 && lim > 0) begin
         step(1);
         lim--;
      end
   endtask

   task automatic t_reset();
      for (int a = 8'h88; a <= 8'h8D; a++) rreg(a[7:0], 8'h00);
      wreg(8'h90, 8'hFF);
      rreg(8'h90, 8'h00);
      check(flg, 4'h0);
   endtask
   task automatic t_run();
      wreg(`DTC_ADDR_MODE, 8'h11);
      rreg(`DTC_ADDR_MODE, 8'h11);
      wreg(`DTC_ADDR_A_LOW, 8'h10);
      wreg(`DTC_ADDR_B_LOW, 8'h20);
      step(40);
      rreg(`DTC_ADDR_A_LOW, 8'h10);
      rreg(`DTC_ADDR_B_LOW, 8'h20);
      wreg(`DTC_ADDR_CTRL, 8'h50);
      step(44);
      wreg(`DTC_ADDR_CTRL, 8'h00);
      rreg(`DTC_ADDR_A_LOW, 8'h14);
      rreg(`DTC_ADDR_B_LOW, 8'h24);
   endtask
   task automatic t_wrap();
      wreg(`DTC_ADDR_MODE, 8'h10);
      wreg(`DTC_ADDR_A_LOW, 8'hFF);
      rreg(`DTC_ADDR_A_LOW, 8'h1F);
      for (int a = 8'h8B; a <= 8'h8D; a++) wreg(a[7:0], 8'hFF);
      wreg(`DTC_ADDR_CTRL, 8'h50);
      wait_hi(0, 30);
      wreg(`DTC_ADDR_CTRL, 8'hA0);
      check(flg[1:0], 2'h3);
      for (int a = 8'h8A; a <= 8'h8D; a++) rreg(a[7:0], 8'h00);
      hit(ack, 0);
      check(flg[0], 1'b0);
      hit(ack, 1);
      check(flg[1], 1'b0);
   endtask
   task automatic t_reload();
      int n;
      wreg(`DTC_ADDR_MODE, 8'h22);
      wreg(`DTC_ADDR_A_HIGH, 8'hFE);
      wreg(`DTC_ADDR_A_LOW, 8'hFE);
      wreg(`DTC_ADDR_CTRL, 8'h10);
      wait_hi(0, 40);
      hit(ack, 0);
      n = 2;
      while (flg[0] !== 1'b1 && n < 60) begin
         step(1);
         n++;
      end
      check(n[7:0], 8'd24);
      wreg(`DTC_ADDR_CTRL, 8'h00);
   endtask
   task automatic t_split();
      wreg(`DTC_ADDR_MODE, 8'h33);
      wreg(`DTC_ADDR_A_LOW, 8'hFF);
      wreg(`DTC_ADDR_A_HIGH, 8'hFF);
      wreg(`DTC_ADDR_CTRL, 8'h50);
      wait_hi(1, 30);
      check(flg[1:0], 2'h3);
      rreg(`DTC_ADDR_B_LOW, 8'h00);
      wreg(`DTC_ADDR_CTRL, 8'h00);
   endtask
   task automatic t_count();
      wreg(`DTC_ADDR_MODE, 8'h95);
      wreg(`DTC_ADDR_A_LOW, 8'h00);
      wreg(`DTC_ADDR_B_LOW, 8'h00);
      wreg(`DTC_ADDR_CTRL, 8'h50);
      step(40);
      rreg(`DTC_ADDR_A_LOW, 8'h00);
      repeat (3) begin
         hit(pulse, 0);
         hit(pulse, 1);
         step(50);
      end
      rreg(`DTC_ADDR_A_LOW, 8'h03);
      rreg(`DTC_ADDR_B_LOW, 8'h03);
      wreg(`DTC_ADDR_CTRL, 8'h00);
   endtask
   task automatic t_ext();
      wreg(`DTC_ADDR_CTRL, 8'h05);
      hit(pulse, 2);
      step(60);
      check(flg[3:2], 2'h1);
      hit(ack, 2);
      check(flg[2], 1'b0);
      hit(pulse, 3);
      step(60);
      check(flg[3], 1'b1);
      hit(ack, 3);
      check(flg[3], 1'b0);
      wreg(`DTC_ADDR_CTRL, 8'h00);
      hit(pulse, 2);
      wait_hi(2, 40);
      check(flg[2], 1'b1);
      step(60);
      check(flg[2], 1'b0);
   endtask

   task automatic close_out();
      $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Main sequence after two cycles of reset.
   initial begin
      step(2);
      sys_rst_i = 1'b0;
      step(1);
      t_reset();
      t_run();
      t_wrap();
      t_reload();
      t_split();
      t_count();
      t_ext();
      close_out();
   end

   // Watchdog: the scenarios need well under 3000 cycles.
   initial begin
      repeat (20000) @(posedge clock_i);
      n_mismatch++;
      close_out();
   end
endmodule // dtc_top_tb

bind dtc_top dtc_top_chk #(.MC_CLKS(MC_CLKS)) chk (.clock_i(clock_i),
   .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
   .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
   .ext_irq_a_input_i(ext_irq_a_input_i), .ext_irq_b_input_i(ext_irq_b_input_i),
   .tmr_a_ack_i(tmr_a_ack_i), .tmr_b_ack_i(tmr_b_ack_i),
   .timer_a_overflow_flag_o(timer_a_overflow_flag_o),
   .timer_b_overflow_flag_o(timer_b_overflow_flag_o),
   .ext_irq_a_edge_flag_o(ext_irq_a_edge_flag_o),
   .ext_irq_b_edge_flag_o(ext_irq_b_edge_flag_o));
